// File: design/cmpms_pkg.sv
//
// Behaviour
// - Mode bits 7:6, 3:2 read zero, ignore writes
// - Mode bit 5 enables rising-edge interrupt
// - Mode bit 4 enables falling-edge interrupt
// - Mode bits 1:0 pick response/power mode
// - Mux bits 7:4 pick negative input pin
// - Mux bits 3:0 pick positive input pin
// - Codes 1010-1111 connect no pin
// - Edges set sticky flags until software clears
// - Enable bit powers comparator; output bit live
package cmpms_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] CMPMS_ADDR_CONTROL = 8'h9b;
   localparam logic [7:0] CMPMS_ADDR_MODE    = 8'h9d;
   localparam logic [7:0] CMPMS_ADDR_MUX     = 8'h9f;
   localparam logic [7:0] CMPMS_RST_MODE     = 8'h02;
   localparam logic [7:0] CMPMS_RST_MUX      = 8'hff;
   localparam logic [7:0] CMPMS_RST_CONTROL  = 8'h00;
   localparam logic [7:0] CMPMS_MODE_MASK    = 8'h33;
   // ==========================================
   // Field positions
   localparam int CMPMS_BIT_RISE_IE = 5;
   localparam int CMPMS_BIT_FALL_IE = 4;
   localparam int CMPMS_BIT_ON      = 7;
   localparam int CMPMS_BIT_OUT     = 6;
   localparam int CMPMS_BIT_RISE_F  = 5;
   localparam int CMPMS_BIT_FALL_F  = 4;
   localparam logic [3:0] CMPMS_SEL_LAST = 4'h9;
   localparam int CMPMS_NUM_PINS    = 20;
   // ==========================================
   // Carriers
   typedef struct packed {
      logic       comparator_on;
      logic [1:0] response_mode;
      logic [3:0] hyst_pos;
      logic [3:0] hyst_neg;
   } cmpms_analog_cfg_t;
   typedef struct packed {
      logic       pos_valid;
      logic [4:0] pos_pin;
      logic       neg_valid;
      logic [4:0] neg_pin;
   } cmpms_route_t;
endpackage : cmpms_pkg

// File: design/cmpms_route_dec.sv
`timescale 1ns/10ps
`default_nettype none
module cmpms_route_dec
   import cmpms_pkg::*;
(
   input  wire logic [7:0]     mux_sel,
   input  wire logic           large_pkg,
   output var cmpms_route_t    route
);
   // ==========================================
   // Pin index: port*8 + bit, odd pins negative
   function automatic logic [5:0] cmpms_pin(input logic [3:0] code, input logic odd);
      logic [5:0] p;
      p = {1'b0, code[3], code[2:0], odd};
      return p;
   endfunction : cmpms_pin
   logic [5:0] neg_idx;
   logic [5:0] pos_idx;
   logic       neg_ok;
   logic       pos_ok;
   // Code 1000/1001 only on large package, above 1001 none
   assign neg_idx = cmpms_pin(mux_sel[7:4], 1'b1);
   assign pos_idx = cmpms_pin(mux_sel[3:0], 1'b0);
   assign neg_ok  = (mux_sel[7:4] <= CMPMS_SEL_LAST) && (!mux_sel[7] || large_pkg);
   assign pos_ok  = (mux_sel[3:0] <= CMPMS_SEL_LAST) && (!mux_sel[3] || large_pkg);
   assign route   = '{pos_ok, pos_idx[4:0], neg_ok, neg_idx[4:0]};
endmodule : cmpms_route_dec
`default_nettype wire

// File: design/cmpms_top.sv
`timescale 1ns/10ps
`default_nettype none
module cmpms_top
   import cmpms_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [7:0]            sfr_addr,
   input  wire logic [7:0]            sfr_wdata,
   input  wire logic                  sfr_wr,
   input  wire logic                  sfr_rd,
   output logic [7:0]                 sfr_rdata,
   input  wire logic                  large_pkg,
   input  wire logic                  cmp_raw,
   output var cmpms_pkg::cmpms_analog_cfg_t analog_cfg,
   output var cmpms_pkg::cmpms_route_t      route,
   output logic                       cmp_irq
);
   import cmpms_pkg::*;
   // ==========================================
   // Registers
   logic [7:0] mode_ff;
   logic [7:0] mux_ff;
   logic [7:0] ctrl_ff;
   logic       out_ff;
   logic       out_q_ff;
   logic [7:0] rdata_ff;
   logic       irq_ff;
   cmpms_analog_cfg_t cfg_ff;
   cmpms_route_t      route_ff;
   cmpms_route_t      nxt_route;
   // Decode
   wire wr_mode = sfr_wr && (sfr_addr == CMPMS_ADDR_MODE);
   wire wr_mux  = sfr_wr && (sfr_addr == CMPMS_ADDR_MUX);
   wire wr_ctrl = sfr_wr && (sfr_addr == CMPMS_ADDR_CONTROL);
   // Edge detect on the comparator output sampled each clock
   wire rise_ev = out_ff && !out_q_ff;
   wire fall_ev = !out_ff && out_q_ff;
   wire [7:0] ctrl_rd = {ctrl_ff[7], out_ff, ctrl_ff[5:0]};
   logic [7:0] nxt_ctrl;
   // Flags set wins over software clear
   always_comb begin
      nxt_ctrl = wr_ctrl ? sfr_wdata : ctrl_ff;
      nxt_ctrl[CMPMS_BIT_OUT] = 1'b0;
      nxt_ctrl[CMPMS_BIT_RISE_F] = nxt_ctrl[CMPMS_BIT_RISE_F] | rise_ev;
      nxt_ctrl[CMPMS_BIT_FALL_F] = nxt_ctrl[CMPMS_BIT_FALL_F] | fall_ev;
   end
   wire nxt_irq = (nxt_ctrl[CMPMS_BIT_RISE_F] && mode_ff[CMPMS_BIT_RISE_IE]) ||
                  (nxt_ctrl[CMPMS_BIT_FALL_F] && mode_ff[CMPMS_BIT_FALL_IE]);
   wire [7:0] nxt_rdata = (sfr_addr == CMPMS_ADDR_MODE)    ? mode_ff :
                          (sfr_addr == CMPMS_ADDR_MUX)     ? mux_ff  :
                          (sfr_addr == CMPMS_ADDR_CONTROL) ? ctrl_rd : 8'h00;
   cmpms_route_dec u_route (
      .mux_sel   (mux_ff),
      .large_pkg (large_pkg),
      .route     (nxt_route)
   );
   // Register writes and status
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff  <= CMPMS_RST_MODE;
         mux_ff   <= CMPMS_RST_MUX;
         ctrl_ff  <= CMPMS_RST_CONTROL;
         out_ff   <= 1'b0;
         out_q_ff <= 1'b0;
      end else begin
         if (wr_mode) mode_ff <= sfr_wdata & CMPMS_MODE_MASK;
         if (wr_mux)  mux_ff  <= sfr_wdata;
         ctrl_ff  <= nxt_ctrl;
         out_ff   <= cmp_raw & ctrl_ff[CMPMS_BIT_ON];
         out_q_ff <= out_ff;
      end
   end
   // Registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= 8'h00;
         irq_ff   <= 1'b0;
         cfg_ff   <= '0;
         route_ff <= '0;
      end else begin
         if (sfr_rd) rdata_ff <= nxt_rdata;
         irq_ff   <= nxt_irq;
         cfg_ff   <= '{ctrl_ff[CMPMS_BIT_ON], mode_ff[1:0],
                       {2'b00, ctrl_ff[3:2]}, {2'b00, ctrl_ff[1:0]}};
         route_ff <= nxt_route;
      end
   end
   assign sfr_rdata  = rdata_ff;
   assign cmp_irq    = irq_ff;
   assign analog_cfg = cfg_ff;
   assign route      = route_ff;
   // ==========================================
   // Checks
   chk_mode_unused: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_ff & ~CMPMS_MODE_MASK) == 8'h00) else $error("mode unused bits set");
   chk_rise_irq: assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_ff[5] && mode_ff[5] && !wr_ctrl) |=> cmp_irq) else $error("rise irq missing");
   chk_fall_irq: assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_ff[4] && mode_ff[4] && !wr_ctrl && !wr_mode) |=> cmp_irq)
      else $error("fall irq missing");
   chk_mode_out: assert property (@(posedge clk) disable iff (!rst_n)
      $stable(mode_ff) |=> analog_cfg.response_mode == $past(mode_ff[1:0]))
      else $error("response mode wrong");
   chk_neg_none: assert property (@(posedge clk) disable iff (!rst_n)
      (mux_ff[7:4] > 4'h9) |=> !route.neg_valid) else $error("neg routed");
   chk_pos_none: assert property (@(posedge clk) disable iff (!rst_n)
      (mux_ff[3:0] > 4'h9) |=> !route.pos_valid) else $error("pos routed");
   chk_rise_flag: assert property (@(posedge clk) disable iff (!rst_n)
      rise_ev |=> ctrl_ff[5]) else $error("rise flag lost");
   chk_off_out: assert property (@(posedge clk) disable iff (!rst_n)
      !ctrl_ff[7] |=> !out_ff) else $error("output while off");
   chk_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_ff[5:4] == 2'b00) ##1 (mode_ff[5:4] == 2'b00) |-> !cmp_irq)
      else $error("irq while disabled");
   // ==========================================
   // Edge to flag and request, both set together one cycle later
   sequence seq_rise_armed;
      rise_ev && mode_ff[CMPMS_BIT_RISE_IE];
   endsequence
   sequence seq_fall_armed;
      fall_ev && mode_ff[CMPMS_BIT_FALL_IE];
   endsequence
   chk_rise_chain: assert property (@(posedge clk) disable iff (!rst_n)
      seq_rise_armed |=> (ctrl_ff[5] && cmp_irq)) else $error("rise chain broken");
   chk_fall_chain: assert property (@(posedge clk) disable iff (!rst_n)
      seq_fall_armed |=> (ctrl_ff[4] && cmp_irq)) else $error("fall chain broken");
   chk_fall_flag: assert property (@(posedge clk) disable iff (!rst_n)
      fall_ev |=> ctrl_ff[4]) else $error("fall flag lost");
   // Flags stay set until software writes the control register
   chk_rise_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_ff[5] && !wr_ctrl) |=> ctrl_ff[5]) else $error("rise flag dropped");
   chk_fall_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_ff[4] && !wr_ctrl) |=> ctrl_ff[4]) else $error("fall flag dropped");
   // Output state follows the comparator while powered
   chk_out_state: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_ff[7] |=> (out_ff == $past(cmp_raw))) else $error("output state stale");
   // Mode write lands masked
   chk_mode_write: assert property (@(posedge clk) disable iff (!rst_n)
      wr_mode |=> (mode_ff == ($past(sfr_wdata) & CMPMS_MODE_MASK)))
      else $error("mode write wrong");
   // Port 2 codes refused on the small package
   chk_small_neg: assert property (@(posedge clk) disable iff (!rst_n)
      (!large_pkg && mux_ff[7]) |=> !route.neg_valid) else $error("neg port 2 routed");
   chk_small_pos: assert property (@(posedge clk) disable iff (!rst_n)
      (!large_pkg && mux_ff[3]) |=> !route.pos_valid) else $error("pos port 2 routed");
   // Read data holds between reads
   chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
endmodule : cmpms_top
`default_nettype wire

// File: verif/cmpms_cmp_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmpms_cmp_model (
   input  wire logic                         clk,
   input  wire logic                         level,
   input  wire cmpms_pkg::cmpms_analog_cfg_t cfg,
   output logic                              cmp_raw
);
   import cmpms_pkg::*;
   // ==========
   // Comparator core: follows level only while powered, low when off
   always_ff @(posedge clk) begin
      cmp_raw <= cfg.comparator_on & level;
   end
endmodule : cmpms_cmp_model
`default_nettype wire

// File: verif/cmpms_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cmpms_top_tb;
   import cmpms_pkg::*;
   logic              clk, rst_n, sfr_wr, sfr_rd, large_pkg, level, cmp_raw, cmp_irq;
   logic [7:0]        sfr_addr, sfr_wdata, sfr_rdata;
   cmpms_analog_cfg_t analog_cfg;
   cmpms_route_t      route;
   int                n_errors = 0;
   int                n_checks = 0;
   cmpms_top cmpms_top_i (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .large_pkg(large_pkg),
      .cmp_raw(cmp_raw), .analog_cfg(analog_cfg), .route(route), .cmp_irq(cmp_irq));
   cmpms_cmp_model cmpms_cmp_model_i (.clk(clk), .level(level), .cfg(analog_cfg),
      .cmp_raw(cmp_raw));
   // ==========
   // Clock and helpers
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : wr
   task rc(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1 chk(n, {4'h0, sfr_rdata}, {4'h0, e});
   endtask : rc
   task conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude
   // ==========
   // Scenarios
   task t_reset;
      rc("mode", CMPMS_ADDR_MODE, 8'h02);
      rc("mux", CMPMS_ADDR_MUX, 8'hff);
      rc("unmapped", 8'h00, 8'h00);
      chk("valid", {route.pos_valid, route.neg_valid}, 12'h000);
      wr(CMPMS_ADDR_MODE, 8'hff);
      rc("mode mask", CMPMS_ADDR_MODE, 8'h33);
      for (int m = 0; m < 4; m++) begin
         wr(CMPMS_ADDR_MODE, 8'(m));
         chk("resp", analog_cfg.response_mode, 12'(m));
      end
      $display("done reset and mode");
   endtask : t_reset
   task t_mux;
      logic [4:0] p;
      for (int i = 0; i < 10; i++) begin
         p = (i < 8) ? 5'((i / 4) * 8 + (i % 4) * 2) : 5'(16 + (i - 8) * 2);
         wr(CMPMS_ADDR_MUX, {4'(i), 4'(i)});
         chk("route", route, {1'b1, p, 1'b1, p + 5'h01});
      end
      large_pkg <= 1'b0;
      wr(CMPMS_ADDR_MUX, 8'h98);
      chk("small pkg", {route.pos_valid, route.neg_valid}, 12'h000);
      for (int j = 10; j < 16; j++) begin
         wr(CMPMS_ADDR_MUX, {4'(j), 4'h0});
         chk("none", {route.pos_valid, route.neg_valid}, 12'h002);
      end
      $display("done mux");
   endtask : t_mux
   task t_irq;
      wr(CMPMS_ADDR_CONTROL, 8'h80);
      wr(CMPMS_ADDR_MODE, 8'h20);
      wr(CMPMS_ADDR_CONTROL, 8'h80);
      level <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("irq rise", cmp_irq, 12'h001);
      rc("ctl rise", CMPMS_ADDR_CONTROL, 8'he0);
      wr(CMPMS_ADDR_CONTROL, 8'h80);
      chk("irq clr", cmp_irq, 12'h000);
      level <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk("fall masked", cmp_irq, 12'h000);
      rc("ctl fall", CMPMS_ADDR_CONTROL, 8'h90);
      wr(CMPMS_ADDR_MODE, 8'h10);
      chk("irq fall", cmp_irq, 12'h001);
      wr(CMPMS_ADDR_CONTROL, 8'h8d);
      chk("cfg", analog_cfg, 12'h431);
      rc("ctl hyst", CMPMS_ADDR_CONTROL, 8'h8d);
      $display("done irq");
   endtask : t_irq
   // ==========
   // Main sequence
   initial begin
      {rst_n, sfr_wr, sfr_rd, level, sfr_addr, sfr_wdata} = '0;
      large_pkg = 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_mux();
      t_irq();
      conclude();
   end
endmodule : cmpms_top_tb
`default_nettype wire
